// File: rtl/ddrl_pkg.sv
// ddr read latency table: shared constants and types for both ends
// assumes the host makes the serial clock from its 25 MHz clock by division
// ****************************************************************
// What this block does
// R01: identifier byte 9ah sits at offset 00h
// R02: length 2ah at 01h; next parameter follows it
// R03: five rows, eight bytes, header row "F","C"
// R04: fast ddr read opcodes 0dh and 0eh
// R05: two-line ddr read opcodes bdh and beh
// R06: four-line ddr read opcodes edh and eeh
// R07: code 11b, 50 MHz: dummies 4,4,3, quad mode 1
// R08: code 00b, 66 MHz: dummies 5,6,6
// R09: code 01b, 66 MHz: dummies 6,7,7
// R10: code 10b, 66 MHz: dummies 7,8,8
// R11: host picks fitting row, inserts listed cycles; this host only reports them on dum_r and never inserts them
// ****************************************************************
package ddrl_pkg;
  // ****************************************************************
  // table layout
  // ****************************************************************
  localparam logic [7:0] OFF_ID = 8'h00;
  localparam logic [7:0] OFF_LEN = 8'h01;
  localparam logic [7:0] OFF_ROWS = 8'h02;
  localparam logic [7:0] OFF_ROWLEN = 8'h03;
  localparam logic [7:0] OFF_HDR = 8'h04;
  localparam logic [7:0] OFF_OPS = 8'h06;
  localparam logic [7:0] OFF_ROW2 = 8'h0c;
  localparam logic [7:0] OFF_LAST = 8'h2b;
  localparam int TBL_BYTES = 44;
  localparam int DATA_ROWS = 4;
  // ****************************************************************
  // table content
  // ****************************************************************
  localparam logic [7:0] PARAM_ID = 8'h9a;
  localparam logic [7:0] PARAM_LEN = 8'h2a;
  localparam logic [7:0] ROW_COUNT = 8'h05;
  localparam logic [7:0] ROW_BYTES = 8'h08;
  localparam logic [7:0] HDR_FREQ = 8'h46;
  localparam logic [7:0] HDR_CODE = 8'h43;
  localparam logic [7:0] OP_FAST_A3 = 8'h0d;
  localparam logic [7:0] OP_FAST_A4 = 8'h0e;
  localparam logic [7:0] OP_DUAL_A3 = 8'hbd;
  localparam logic [7:0] OP_DUAL_A4 = 8'hbe;
  localparam logic [7:0] OP_QUAD_A3 = 8'hed;
  localparam logic [7:0] OP_QUAD_A4 = 8'hee;
  localparam logic [7:0] FREQ_50 = 8'h32;
  localparam logic [7:0] FREQ_66 = 8'h42;
  localparam logic [7:0] CODE_00 = 8'h00;
  localparam logic [7:0] CODE_01 = 8'h01;
  localparam logic [7:0] CODE_10 = 8'h02;
  localparam logic [7:0] CODE_11 = 8'h03;
  localparam logic [7:0] MODE_NONE = 8'h00;
  localparam logic [7:0] MODE_QUAD = 8'h01;
  localparam logic [7:0] DUM_C11_FAST = 8'h04;
  localparam logic [7:0] DUM_C11_DUAL = 8'h04;
  localparam logic [7:0] DUM_C11_QUAD = 8'h03;
  localparam logic [7:0] DUM_C00_FAST = 8'h05;
  localparam logic [7:0] DUM_C00_MULTI = 8'h06;
  localparam logic [7:0] DUM_C01_FAST = 8'h06;
  localparam logic [7:0] DUM_C01_MULTI = 8'h07;
  localparam logic [7:0] DUM_C10_FAST = 8'h07;
  localparam logic [7:0] DUM_C10_MULTI = 8'h08;
  localparam logic [7:0] OUT_OF_RANGE = 8'h00;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCK_PERIOD_NS = 160;
  localparam int SCK_DIV = SCK_PERIOD_NS / CLK_PERIOD_NS;
  // serial clock rate rounded up, compared with a row ceiling
  localparam logic [7:0] SCK_MHZ_CEIL = 8'((1000 + SCK_PERIOD_NS - 1) / SCK_PERIOD_NS);
  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic {DS_OFFSET = 1'b0, DS_DATA = 1'b1} ddrl_dst_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_CMD = 2'b01, HS_DATA = 2'b10, HS_PARSE = 2'b11
  } ddrl_hst_t;
endpackage : ddrl_pkg

// File: rtl/ddrl_if.sv
// link between the query table end and the host end
// assumes the bench resolves nothing: every pin has a single driver
`timescale 1ns/1ns
interface ddrl_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  modport dev (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input so, input so_oe);
endinterface : ddrl_if

// File: rtl/ddrl_dev.sv
// query table end: serves the ddr latency table over the serial link
// assumes sck runs only while cs_n is low; cs_n high clears the frame
`timescale 1ns/1ns
module ddrl_dev import ddrl_pkg::*; (
  // link
  ddrl_if.dev lk,
  // user side status, sck domain
  output logic serving,
  output logic [7:0] cur_off,
  output logic [5:0] bytes_sent
);
  // ****************************************************************
  // table image
  // ****************************************************************
  localparam logic [7:0] TBL [0:TBL_BYTES-1] = '{
    PARAM_ID, // R01
    PARAM_LEN, // R02
    ROW_COUNT, // R03
    ROW_BYTES, // R03
    HDR_FREQ, // R03
    HDR_CODE, // R03
    OP_FAST_A3, // R04
    OP_FAST_A4, // R04
    OP_DUAL_A3, // R05
    OP_DUAL_A4, // R05
    OP_QUAD_A3, // R06
    OP_QUAD_A4, // R06
    // row 2
    FREQ_50, // R07
    CODE_11, // R07
    MODE_NONE,
    DUM_C11_FAST, // R07
    MODE_NONE,
    DUM_C11_DUAL, // R07
    MODE_QUAD, // R07
    DUM_C11_QUAD, // R07
    // row 3
    FREQ_66, // R08
    CODE_00, // R08
    MODE_NONE,
    DUM_C00_FAST, // R08
    MODE_NONE,
    DUM_C00_MULTI, // R08
    MODE_QUAD,
    DUM_C00_MULTI, // R08
    // row 4
    FREQ_66, // R09
    CODE_01, // R09
    MODE_NONE,
    DUM_C01_FAST, // R09
    MODE_NONE,
    DUM_C01_MULTI, // R09
    MODE_QUAD,
    DUM_C01_MULTI, // R09
    // row 5
    FREQ_66, // R10
    CODE_10, // R10
    MODE_NONE,
    DUM_C10_FAST, // R10
    MODE_NONE,
    DUM_C10_MULTI, // R10
    MODE_QUAD,
    DUM_C10_MULTI // R10
  };

  // ****************************************************************
  // table lookup
  // ****************************************************************
  // offsets past the table read as zero rather than aliasing
  function automatic logic [7:0] tbl_rd(input logic [7:0] a);
    logic [7:0] v;
    v = OUT_OF_RANGE;
    if (a <= OFF_LAST) begin
      v = TBL[a[5:0]];
    end
    return v;
  endfunction : tbl_rd

  // ****************************************************************
  // frame state
  // ****************************************************************
  ddrl_dst_t st_r;
  ddrl_dst_t st_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [5:0] sent_r;
  logic [5:0] sent_nxt;

  // offset phase shifts in eight bits, then bytes stream out msb first
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 3'd1;
    addr_nxt = addr_r;
    ptr_nxt = ptr_r;
    sh_nxt = sh_r;
    sent_nxt = sent_r;
    case (st_r)
      DS_OFFSET: begin
        addr_nxt = {addr_r[6:0], lk.si};
        if (cnt_r == 3'd7) begin
          // first byte loaded on the eighth edge so it is on the pin at once
          st_nxt = DS_DATA;
          ptr_nxt = addr_nxt;
          sh_nxt = tbl_rd(addr_nxt); // R01
        end
      end
      DS_DATA: begin
        if (cnt_r == 3'd7) begin
          // auto increment lets a host read the whole table in one frame
          ptr_nxt = ptr_r + 8'd1;
          sh_nxt = tbl_rd(ptr_nxt); // R02
          sent_nxt = sent_r + 6'd1;
        end else begin
          sh_nxt = {sh_r[6:0], 1'b0};
        end
      end
      default: begin
        st_nxt = DS_OFFSET;
      end
    endcase
  end

  // cs_n high is the only reset: the link clock stops between frames
  always_ff @(posedge lk.sck or posedge lk.cs_n) begin
    if (lk.cs_n) begin
      st_r <= DS_OFFSET;
      cnt_r <= 3'h0;
      addr_r <= 8'h00;
      ptr_r <= 8'h00;
      sh_r <= 8'h00;
      sent_r <= 6'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      ptr_r <= ptr_nxt;
      sh_r <= sh_nxt;
      sent_r <= sent_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // so_oe is high only while a byte is being served; so itself always carries sh_r[7]
  assign lk.so = sh_r[7];
  assign lk.so_oe = (st_r == DS_DATA);
  assign serving = (st_r == DS_DATA);
  assign cur_off = ptr_r;
  assign bytes_sent = sent_r;
endmodule : ddrl_dev

// File: rtl/ddrl_host.sv
// host end: reads the ddr latency table and picks the read settings
// assumes clock at 25 MHz; sck is clock divided by four
`timescale 1ns/1ns
module ddrl_host import ddrl_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // link
  ddrl_if.host lk,
  // user request
  input wire logic start,
  input wire logic [1:0] want_code,
  // user answer
  output logic busy,
  output logic done,
  output logic ok,
  output logic [7:0] op_r [0:5],
  output logic [7:0] mode_r [0:2],
  output logic [7:0] dum_r [0:2]
);
  // ****************************************************************
  // state
  // ****************************************************************
  ddrl_hst_t st_r, st_nxt;
  logic [1:0] div_r, div_nxt, want_r, want_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt;
  logic [5:0] idx_r, idx_nxt;
  logic sck_r, sck_nxt, csn_r, csn_nxt, done_r, done_nxt, ok_r, ok_nxt;
  logic we;
  logic so_m_r, so_s_r;
  logic [7:0] mem_r [0:63];
  logic [7:0] op_nxt [0:5];
  logic [7:0] mode_nxt [0:2];
  logic [7:0] dum_nxt [0:2];
  logic act;

  // so comes from the sck domain: two flops before anything reads it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      so_m_r <= 1'b0;
      so_s_r <= 1'b0;
    end else begin
      so_m_r <= lk.so;
      so_s_r <= so_m_r;
    end
  end

  // ****************************************************************
  // sequencer and parser
  // ****************************************************************
  always_comb begin
    int base;
    int sel;
    logic hit;
    base = 0;
    sel = int'(OFF_ROW2);
    hit = 1'b0;
    st_nxt = st_r;
    div_nxt = div_r + 2'd1;
    want_nxt = want_r;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    idx_nxt = idx_r;
    we = 1'b0;
    done_nxt = 1'b0;
    ok_nxt = ok_r;
    op_nxt = op_r;
    mode_nxt = mode_r;
    dum_nxt = dum_r;
    case (st_r)
      HS_IDLE: begin
        div_nxt = 2'd0;
        if (start) begin
          st_nxt = HS_CMD;
          want_nxt = want_code;
          tx_nxt = OFF_ID;
          bit_nxt = 3'd0;
          idx_nxt = 6'd0;
        end
      end
      HS_CMD: begin
        // si moves after the device has sampled on the rising edge
        if (div_r == 2'd3) begin
          tx_nxt = {tx_r[6:0], 1'b0};
          bit_nxt = bit_r + 3'd1;
          if (bit_r == 3'd7) begin
            st_nxt = HS_DATA;
          end
        end
      end
      HS_DATA: begin
        // sampled late in the low phase, well after the synchroniser settles
        if (div_r == 2'd1) begin
          rx_nxt = {rx_r[6:0], so_s_r};
          bit_nxt = bit_r + 3'd1;
          if (bit_r == 3'd7) begin
            we = 1'b1;
            idx_nxt = idx_r + 6'd1;
            // stop at length plus one; the array bound guards a bad length
            if ((idx_r >= 6'd2 && {2'b00, idx_r} == mem_r[OFF_LEN[5:0]] + 8'd1) || idx_r == 6'd63) begin // R02
              st_nxt = HS_PARSE;
            end
          end
        end
      end
      HS_PARSE: begin
        for (int r = 0; r < DATA_ROWS; r++) begin
          base = int'(OFF_ROW2) + r * int'(ROW_BYTES);
          // first row with the wanted code whose ceiling covers our sck
          if (!hit && mem_r[6'(base + 1)][1:0] == want_r && mem_r[6'(base)] >= SCK_MHZ_CEIL) begin // R11
            hit = 1'b1;
            sel = base;
          end
        end
        for (int k = 0; k < 6; k++) begin
          op_nxt[k] = mem_r[6'(int'(OFF_OPS) + k)]; // R04 R05 R06
        end
        for (int j = 0; j < 3; j++) begin
          mode_nxt[j] = mem_r[6'(sel + 2 + 2 * j)]; // R07
          dum_nxt[j] = mem_r[6'(sel + 3 + 2 * j)]; // R08 R09 R10
        end
        ok_nxt = hit && mem_r[OFF_ID[5:0]] == PARAM_ID && mem_r[OFF_ROWS[5:0]] == ROW_COUNT
          && mem_r[OFF_ROWLEN[5:0]] == ROW_BYTES && mem_r[OFF_HDR[5:0]] == HDR_FREQ;
        done_nxt = 1'b1;
        st_nxt = HS_IDLE;
      end
      default: begin
        st_nxt = HS_IDLE;
      end
    endcase
    act = (st_nxt == HS_CMD) || (st_nxt == HS_DATA);
    csn_nxt = !act;
    sck_nxt = act && div_nxt[1];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= HS_IDLE;
      div_r <= 2'd0;
      want_r <= 2'd0;
      bit_r <= 3'd0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      idx_r <= 6'd0;
      sck_r <= 1'b0;
      csn_r <= 1'b1;
      done_r <= 1'b0;
      ok_r <= 1'b0;
      op_r <= '{default: 8'h00};
      mode_r <= '{default: 8'h00};
      dum_r <= '{default: 8'h00};
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      want_r <= want_nxt;
      bit_r <= bit_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      idx_r <= idx_nxt;
      sck_r <= sck_nxt;
      csn_r <= csn_nxt;
      done_r <= done_nxt;
      ok_r <= ok_nxt;
      op_r <= op_nxt;
      mode_r <= mode_nxt;
      dum_r <= dum_nxt;
    end
  end

  // received bytes; no reset needed, parsed only after a full read
  always_ff @(posedge clock) begin
    if (we) begin
      mem_r[idx_r] <= rx_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign lk.cs_n = csn_r;
  assign lk.sck = sck_r;
  assign lk.si = tx_r[7];
  assign busy = (st_r != HS_IDLE);
  assign done = done_r;
  assign ok = ok_r;
endmodule : ddrl_host

// File: dv/ddrl_chk_sva.sv
// checker: rebuilds the bytes seen on so and ties each one to its table place
// assumes sck comes from the host clock, so sck edges are seen as clock samples
`timescale 1ns/1ns
module ddrl_chk_sva import ddrl_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  // ****************************************************************
  // expected table, written from the documented bytes
  // ****************************************************************
  localparam logic [7:0] EXP [0:43] = '{
    8'h9a, 8'h2a, 8'h05, 8'h08, 8'h46, 8'h43, 8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee,
    8'h32, 8'h03, 8'h00, 8'h04, 8'h00, 8'h04, 8'h01, 8'h03, 8'h42, 8'h00, 8'h00, 8'h05,
    8'h00, 8'h06, 8'h01, 8'h06, 8'h42, 8'h01, 8'h00, 8'h06, 8'h00, 8'h07, 8'h01, 8'h07,
    8'h42, 8'h02, 8'h00, 8'h07, 8'h00, 8'h08, 8'h01, 8'h08};
  logic sck_q_r, sck_q_nxt, got_r, got_nxt;
  logic [9:0] cnt_r, cnt_nxt, d;
  logic [7:0] sh_r, sh_nxt;
  logic [5:0] idx_r, idx_nxt;
  // so is taken at the sck fall, half a period after the device moved it
  always_comb begin
    d = cnt_r - 10'd7;
    sck_q_nxt = sck;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    got_nxt = 1'b0;
    idx_nxt = idx_r;
    if (cs_n) begin
      cnt_nxt = '0; // a dropped frame restarts the count
    end else if (sck_q_r && !sck) begin
      cnt_nxt = cnt_r + 10'd1;
      sh_nxt = {sh_r[6:0], so};
      got_nxt = (cnt_r >= 10'd7) && (d[2:0] == 3'd7);
      idx_nxt = d[8:3];
    end
  end
  // helper registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sck_q_r <= 1'b0;
      cnt_r <= '0;
      sh_r <= '0;
      got_r <= 1'b0;
      idx_r <= '0;
    end else begin
      sck_q_r <= sck_q_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      got_r <= got_nxt;
      idx_r <= idx_nxt;
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_id; got_r && idx_r == 6'd0 |-> sh_r == 8'h9a; endproperty
  a_id: assert property (p_id) else $error("identifier byte wrong");
  property p_len; got_r && idx_r == 6'd1 |-> sh_r == 8'h2a; endproperty
  a_len: assert property (p_len) else $error("length byte wrong");
  property p_hdr; got_r && idx_r inside {[6'd2:6'd5]} |-> sh_r == EXP[idx_r]; endproperty
  a_hdr: assert property (p_hdr) else $error("row count or header wrong");
  property p_fast; got_r && idx_r inside {6'd6, 6'd7} |-> sh_r == EXP[idx_r]; endproperty
  a_fast: assert property (p_fast) else $error("fast read opcode wrong");
  property p_dual; got_r && idx_r inside {6'd8, 6'd9} |-> sh_r == EXP[idx_r]; endproperty
  a_dual: assert property (p_dual) else $error("dual read opcode wrong");
  property p_quad; got_r && idx_r inside {6'd10, 6'd11} |-> sh_r == EXP[idx_r]; endproperty
  a_quad: assert property (p_quad) else $error("quad read opcode wrong");
  property p_row11; got_r && idx_r inside {[6'h0c:6'h13]} |-> sh_r == EXP[idx_r]; endproperty
  a_row11: assert property (p_row11) else $error("code 11 row wrong");
  property p_row00; got_r && idx_r inside {[6'h14:6'h1b]} |-> sh_r == EXP[idx_r]; endproperty
  a_row00: assert property (p_row00) else $error("code 00 row wrong");
  property p_row01; got_r && idx_r inside {[6'h1c:6'h23]} |-> sh_r == EXP[idx_r]; endproperty
  a_row01: assert property (p_row01) else $error("code 01 row wrong");
  property p_row10; got_r && idx_r inside {[6'h24:6'h2b]} |-> sh_r == EXP[idx_r]; endproperty
  a_row10: assert property (p_row10) else $error("code 10 row wrong");
  property p_oe; $fell(cs_n) |-> !so_oe [*8]; endproperty
  a_oe: assert property (p_oe) else $error("device drove during offset");
  property p_off; !cs_n && !so_oe |-> !si; endproperty
  a_off: assert property (p_off) else $error("offset bits not zero");
endmodule : ddrl_chk_sva

// File: dv/tb.sv
// bench: host end reads the table from the device end across the link
// assumes the host makes sck itself; the bench drives only user inputs
`timescale 1ns/1ns
module tb import ddrl_pkg::*;;
  logic clock, rstn, start, busy, done, ok, serving;
  logic [1:0] want_code;
  logic [7:0] cur_off;
  logic [5:0] bytes_sent;
  logic [7:0] op [0:5];
  logic [7:0] mode [0:2];
  logic [7:0] dum [0:2];
  int n_errors, cmp_count;
  // expected results per latency code, in fast, dual, quad order
  logic [7:0] exp_op [0:5] = '{8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee};
  logic [7:0] exp_mode [0:2] = '{8'h00, 8'h00, 8'h01};
  logic [7:0] exp_dum [0:3][0:2] = '{'{8'h05, 8'h06, 8'h06}, '{8'h06, 8'h07, 8'h07},
    '{8'h07, 8'h08, 8'h08}, '{8'h04, 8'h04, 8'h03}};
  ddrl_if lk_if();
  ddrl_host ddrl_host_inst(.clock(clock), .rstn(rstn), .lk(lk_if), .start(start), .want_code(want_code),
    .busy(busy), .done(done), .ok(ok), .op_r(op), .mode_r(mode), .dum_r(dum));
  ddrl_dev ddrl_dev_inst(.lk(lk_if), .serving(serving), .cur_off(cur_off), .bytes_sent(bytes_sent));
  ddrl_chk_sva ddrl_chk_sva_inst(.clock(clock), .rstn(rstn), .cs_n(lk_if.cs_n), .sck(lk_if.sck),
    .si(lk_if.si), .so(lk_if.so), .so_oe(lk_if.so_oe));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : cmp1
  task automatic kick(input logic [1:0] code);
    @(negedge clock);
    start = 1'b1;
    want_code = code;
    @(negedge clock);
    start = 1'b0;
  endtask : kick
  // bounded wait; a full read takes about 1450 cycles
  task automatic wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    cmp1(done, 1'b1, "done");
  endtask : wait_done
  task automatic check_res(input int code);
    cmp1(ok, 1'b1, "ok");
    for (int i = 0; i < 6; i++) cmp8(op[i], exp_op[i], "opcode");
    for (int i = 0; i < 3; i++) cmp8(mode[i], exp_mode[i], "mode");
    for (int i = 0; i < 3; i++) cmp8(dum[i], exp_dum[code][i], "dummy");
    @(negedge clock);
    cmp1(lk_if.cs_n, 1'b1, "cs_n idle");
    cmp1(lk_if.sck, 1'b0, "sck idle");
    cmp1(lk_if.so_oe, 1'b0, "so_oe idle");
    cmp1(serving, 1'b0, "serving idle");
  endtask : check_res
  task automatic conclude;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // ****************************************************************
  // clock, watchdog and sequence
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // seven reads of about 60 us each fit well inside this span
  initial begin
    #1000000;
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    conclude();
  end
  initial begin
    rstn = 1'b0;
    start = 1'b0;
    want_code = 2'd0;
    n_errors = 0;
    cmp_count = 0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    // every latency code picks its own row
    for (int c = 0; c < 4; c++) begin
      kick(2'(c));
      wait_done();
      check_res(c);
      $display("test code %0d ended", c);
    end
    // a second request while busy must not change the answer
    // start stays high across the take, so it is never lowered and raised in one step
    @(negedge clock);
    start = 1'b1;
    want_code = 2'd1;
    @(negedge clock);
    want_code = 2'd3;
    repeat (50) @(negedge clock);
    cmp1(busy, 1'b1, "busy");
    start = 1'b0;
    wait_done();
    check_res(1);
    $display("test busy refusal ended");
    // reset in mid-frame drops the link to idle, then a clean read follows
    kick(2'd0);
    repeat (400) @(negedge clock);
    // byte k loads 30 + 32k cycles after the take: byte 0bh is shifting out now
    cmp1(serving, 1'b1, "serving mid frame");
    cmp8(cur_off, 8'h0b, "offset mid frame");
    cmp8({2'b00, bytes_sent}, 8'h0b, "bytes mid frame");
    rstn = 1'b0;
    @(negedge clock);
    cmp1(lk_if.cs_n, 1'b1, "cs_n in reset");
    cmp1(busy, 1'b0, "busy in reset");
    rstn = 1'b1;
    kick(2'd2);
    wait_done();
    check_res(2);
    $display("test mid reset ended");
    conclude();
  end
endmodule : tb
